// ---- rtl/front_end_pkg.sv ----
/*
  Shared constants of the instruction decode front end: word and field
  layout, operand modes, index operations, reset values and counts.
  Assumes nothing of its surroundings.
*/
package front_end_pkg;
  localparam int WORD_W = 30;
  localparam int ADDR_W = 15;
  localparam int OPC_W  = 6;
  localparam int FLD_W  = 3;
  localparam int SHC_W  = 6;

  // field positions, most significant first
  localparam int OPC_LSB  = 24;
  localparam int SKIP_LSB = 21;
  localparam int MODE_LSB = 18;
  localparam int IDX_LSB  = 15;
  localparam int LOC_LSB  = 0;

  localparam logic [OPC_W-1:0] OPC_FAULT_LO = 6'h00;
  localparam logic [OPC_W-1:0] OPC_FAULT_HI = 6'h3f;

  localparam logic [SHC_W-1:0] SHIFT_MAX    = 6'h3f;
  localparam logic [SHC_W-1:0] MULDIV_STEPS = 6'h1e;
  localparam logic [SHC_W-1:0] SHC_RST      = 6'h00;

  localparam logic [WORD_W-1:0] WORD_RST = 30'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;

  typedef enum logic [2:0] {
    MODE_U_LOW  = 3'h0,
    MODE_Z_LOW  = 3'h1,
    MODE_Z_HIGH = 3'h2,
    MODE_Z_FULL = 3'h3,
    MODE_U_SEXT = 3'h4,
    MODE_Z_LSX  = 3'h5,
    MODE_Z_HSX  = 3'h6,
    MODE_SUM    = 3'h7
  } operand_mode_t;

  typedef enum logic [1:0] {
    IDX_LOAD = 2'h0,
    IDX_INC  = 2'h1,
    IDX_CPL  = 2'h2,
    IDX_READ = 2'h3
  } index_op_t;
endpackage : front_end_pkg

// ---- rtl/shift_ctl_if.sv ----
/*
  Control and status between the front end and its shift counter.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ps
interface shift_ctl_if;
  logic                            load;
  logic [front_end_pkg::SHC_W-1:0] loadVal;
  logic                            step;
  logic [front_end_pkg::SHC_W-1:0] count;
  logic                            zero;

  modport ctrl (output load, output loadVal, output step, input count, input zero);
  modport cnt  (input load, input loadVal, input step, output count, output zero);
endinterface : shift_ctl_if

// ---- rtl/ones_comp_add15.sv ----
/*
  15-bit ones'-complement adder with end-around carry (modulus 2^15-1).
  Assumes purely combinational use by the caller.
*/
`timescale 1ns/1ps
module ones_comp_add15 (
  // operands
  input  wire logic [front_end_pkg::ADDR_W-1:0] a,
  input  wire logic [front_end_pkg::ADDR_W-1:0] b,
  // result
  output wire logic [front_end_pkg::ADDR_W-1:0] sum
);
  wire logic [front_end_pkg::ADDR_W:0] raw;
  assign raw = {1'b0, a} + {1'b0, b};
  // end-around carry cannot ripple out again: max is 7ffe + 1
  assign sum = raw[front_end_pkg::ADDR_W-1:0]
             + {{(front_end_pkg::ADDR_W-1){1'b0}}, raw[front_end_pkg::ADDR_W]};
endmodule : ones_comp_add15

// ---- rtl/shift_counter.sv ----
/*
  Six-bit shift step counter with load, step-down and registered zero flag.
  Assumes control from the front end on the same clock.
*/
`timescale 1ns/1ps
module shift_counter (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  shift_ctl_if.cnt  sc
);
  logic [front_end_pkg::SHC_W-1:0] count_q;
  logic                            zero_q;
  wire logic [front_end_pkg::SHC_W-1:0] count_d;

  // stepping an empty counter is ignored, it never wraps to 63
  assign count_d = sc.load ? sc.loadVal
                 : (sc.step && !zero_q) ? count_q - 6'h01 : count_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= front_end_pkg::SHC_RST;
      zero_q  <= 1'b1;
    end else begin
      count_q <= count_d;
      zero_q  <= (count_d == front_end_pkg::SHC_RST);
    end
  end

  assign sc.count = count_q;
  assign sc.zero  = zero_q;
endmodule : shift_counter

// ---- rtl/instruction_decode_front_end.sv ----
/*
  Instruction decode and operand fetch front end: holds the instruction,
  indexes the operand address, runs one core storage access, shapes the
  operand and evaluates the skip condition.
  Assumes storage and arithmetic registers on core_clk; sense data is
  valid in the same cycle as the read strobe.
*/
// Summary of operation
// - 30-bit operand register complements, never shifts, holds operand through arithmetic.
// - sum and multiplier registers exchange data only via the operand register.
// - six-bit shift counter counts shifts, largest count 63.
// - multiply and divide preload the shift counter with 30, step to zero.
// - storage address latch loaded at access start, decoded to selection lines.
// - read half clears read buffer, then samples sense amplifiers into it.
// - write half drives inhibit lines from read buffer, restoring the word.
// - instruction held whole execution; fields decoded from fixed bit positions.
// - low 15 instruction bits add ones'-complement with end-around carry.
// - selected index register added to address bits before execution.
// - index transfers pass a 15-bit link latch that complements and counts.
// - fields: opcode 6, skip 3, operand mode 3, index 3, location 15.
// - first step adds index register chosen by index select to location.
// - second step normally reads storage at modified address into read buffer.
// - third step moves read buffer to operand register shaped by mode.
// - then operational registers update and next fetch follows skip condition.
// - opcodes 00 and 77 halt computation and light the fault indicator.
// - skip condition 0 never skips, 1 always skips.
// - skip condition 2 skips on multiplier positive, 3 on negative.
// - skip condition 4 skips on sum zero, 5 on nonzero.
// - skip condition 6 skips on sum positive, 7 on negative.
// - during repeat, skip condition decides when repeat mode ends.
// - read with mode 3 loads all 30 read buffer bits unchanged.
`timescale 1ns/1ps
module instruction_decode_front_end (
  // clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // instruction entry
  input  wire logic                                instrValid,
  input  wire logic [front_end_pkg::WORD_W-1:0]    instrWord,
  input  wire logic                                repeatActive,
  // arithmetic side
  input  wire logic [front_end_pkg::WORD_W-1:0]    sumReg,
  input  wire logic [front_end_pkg::WORD_W-1:0]    multReg,
  input  wire logic                                arithLoad,
  input  wire logic [front_end_pkg::WORD_W-1:0]    arithData,
  input  wire logic                                operandCpl,
  // shift control
  input  wire logic                                shiftLoad,
  input  wire logic [front_end_pkg::SHC_W-1:0]     shiftLoadVal,
  input  wire logic                                mulDivStart,
  input  wire logic                                shiftStep,
  // index register access
  input  wire logic                                idxReq,
  input  wire front_end_pkg::index_op_t            idxOp,
  input  wire logic [front_end_pkg::FLD_W-1:0]     idxSel,
  input  wire logic [front_end_pkg::ADDR_W-1:0]    idxData,
  // core storage
  input  wire logic [front_end_pkg::WORD_W-1:0]    senseData,
  output logic      [front_end_pkg::ADDR_W-1:0]    memAddr,
  output logic                                     memRead,
  output logic                                     memWrite,
  output logic      [front_end_pkg::WORD_W-1:0]    inhibitData,
  // decoded fields
  output logic      [front_end_pkg::OPC_W-1:0]     opCode,
  output logic      [front_end_pkg::FLD_W-1:0]     skipCond,
  output logic      [front_end_pkg::FLD_W-1:0]     operandMode,
  output logic      [front_end_pkg::FLD_W-1:0]     indexSel,
  output logic      [front_end_pkg::ADDR_W-1:0]    operandLoc,
  // results and status
  output logic      [front_end_pkg::WORD_W-1:0]    operandOut,
  output logic                                     operandReady,
  output logic                                     skipNext,
  output logic                                     repeatExit,
  output logic                                     busy,
  output logic                                     fault,
  output logic      [front_end_pkg::ADDR_W-1:0]    idxLink,
  output logic      [front_end_pkg::SHC_W-1:0]     shiftCount,
  output logic                                     shiftZero
);
  localparam int AW = front_end_pkg::ADDR_W;
  localparam int WW = front_end_pkg::WORD_W;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_MODIFY = 4'h1,
    ST_ADDIDX = 4'h2,
    ST_ADDR   = 4'h3,
    ST_RDCLR  = 4'h4,
    ST_RDSAMP = 4'h5,
    ST_WRBACK = 4'h6,
    ST_XFER   = 4'h7,
    ST_SKIP   = 4'h8,
    ST_FAULT  = 4'h9,
    ST_IXOP   = 4'ha,
    ST_IXWR   = 4'hb
  } state_t;

  state_t            state_q;
  state_t            state_d;
  logic [WW-1:0]     cmd_q;
  logic [WW-1:0]     operand_q;
  logic [WW-1:0]     readBuf_q;
  logic [AW-1:0]     addrLatch_q;
  logic [AW-1:0]     link_q;
  logic [AW-1:0]     index_q [1:7];
  logic [2:0]        ixSel_q;
  logic [1:0]        ixOp_q;
  logic              memRead_q;
  logic              memWrite_q;
  logic              ready_q;
  logic              skip_q;
  logic              repExit_q;
  logic              fault_q;

  shift_ctl_if sc ();

  shift_counter u_shift (
    .core_clk (core_clk),
    .rst      (rst),
    .sc       (sc)
  );

  // preset for multiply/divide takes priority over an explicit load
  assign sc.load    = mulDivStart || shiftLoad;
  assign sc.loadVal = mulDivStart ? front_end_pkg::MULDIV_STEPS : shiftLoadVal;
  assign sc.step    = shiftStep && !sc.load;

  // fixed field positions of the held instruction
  wire logic [front_end_pkg::OPC_W-1:0] fOpc;
  wire logic [2:0]                      fSkip;
  wire logic [2:0]                      fMode;
  wire logic [2:0]                      fIdx;
  wire logic [AW-1:0]                   fLoc;
  assign fOpc  = cmd_q[front_end_pkg::OPC_LSB +: front_end_pkg::OPC_W];
  assign fSkip = cmd_q[front_end_pkg::SKIP_LSB +: front_end_pkg::FLD_W];
  assign fMode = cmd_q[front_end_pkg::MODE_LSB +: front_end_pkg::FLD_W];
  assign fIdx  = cmd_q[front_end_pkg::IDX_LSB +: front_end_pkg::FLD_W];
  assign fLoc  = cmd_q[front_end_pkg::LOC_LSB +: AW];

  wire logic isFault;
  wire logic needsRead;
  assign isFault = (fOpc == front_end_pkg::OPC_FAULT_LO)
                || (fOpc == front_end_pkg::OPC_FAULT_HI);
  // modes 0, 4 and 7 take no operand from storage
  assign needsRead = !(fMode == front_end_pkg::MODE_U_LOW
                    || fMode == front_end_pkg::MODE_U_SEXT
                    || fMode == front_end_pkg::MODE_SUM);

  // address modification and link counting share one adder style
  wire logic [AW-1:0] modLoc;
  wire logic [AW-1:0] linkInc;
  ones_comp_add15 u_addmod (
    .a   (fLoc),
    .b   (link_q),
    .sum (modLoc)
  );
  ones_comp_add15 u_addinc (
    .a   (link_q),
    .b   (front_end_pkg::ADDR_ONE),
    .sum (linkInc)
  );

  wire logic [AW-1:0] idxValue;
  assign idxValue = (fIdx == 3'h0) ? front_end_pkg::ADDR_RST : index_q[fIdx];

  // operand shaping, clear-then-transmit folded into one load
  wire logic [AW-1:0] lowSrc;
  wire logic          sext;
  wire logic [WW-1:0] shaped;
  assign lowSrc = (fMode == front_end_pkg::MODE_U_LOW || fMode == front_end_pkg::MODE_U_SEXT)
                ? fLoc
                : (fMode == front_end_pkg::MODE_Z_HIGH || fMode == front_end_pkg::MODE_Z_HSX)
                ? readBuf_q[WW-1:AW] : readBuf_q[AW-1:0];
  assign sext   = (fMode == front_end_pkg::MODE_U_SEXT || fMode == front_end_pkg::MODE_Z_LSX
                || fMode == front_end_pkg::MODE_Z_HSX) && lowSrc[AW-1];
  assign shaped = (fMode == front_end_pkg::MODE_Z_FULL) ? readBuf_q
                : (fMode == front_end_pkg::MODE_SUM) ? sumReg
                : {{AW{sext}}, lowSrc};

  // skip condition, sign in the top bit
  wire logic multNeg;
  wire logic sumNeg;
  wire logic sumZero;
  wire logic skipHit;
  assign multNeg = multReg[WW-1];
  assign sumNeg  = sumReg[WW-1];
  assign sumZero = (sumReg == front_end_pkg::WORD_RST);
  assign skipHit = (fSkip == 3'h0) ? 1'b0
                 : (fSkip == 3'h1) ? 1'b1
                 : (fSkip == 3'h2) ? !multNeg
                 : (fSkip == 3'h3) ? multNeg
                 : (fSkip == 3'h4) ? sumZero
                 : (fSkip == 3'h5) ? !sumZero
                 : (fSkip == 3'h6) ? !sumNeg
                 : sumNeg;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (instrValid) begin
          state_d = ST_MODIFY;
        end else if (idxReq) begin
          state_d = (idxOp == front_end_pkg::IDX_LOAD) ? ST_IXWR : ST_IXOP;
        end
      end
      ST_MODIFY: state_d = ST_ADDIDX;
      ST_ADDIDX: state_d = isFault ? ST_FAULT : (needsRead ? ST_ADDR : ST_XFER);
      ST_ADDR:   state_d = ST_RDCLR;
      ST_RDCLR:  state_d = ST_RDSAMP;
      ST_RDSAMP: state_d = ST_WRBACK;
      ST_WRBACK: state_d = ST_XFER;
      ST_XFER:   state_d = ST_SKIP;
      ST_SKIP:   state_d = ST_IDLE;
      ST_FAULT:  state_d = ST_FAULT;
      ST_IXOP:   state_d = ST_IXWR;
      ST_IXWR:   state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // instruction hold: loaded once, only the address part is rewritten
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_q <= front_end_pkg::WORD_RST;
    end else if (state_q == ST_IDLE && instrValid) begin
      cmd_q <= instrWord;
    end else if (state_q == ST_ADDIDX) begin
      cmd_q[AW-1:0] <= modLoc;
    end
  end

  // link latch: every index transfer passes here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_q  <= front_end_pkg::ADDR_RST;
      ixSel_q <= 3'h0;
      ixOp_q  <= front_end_pkg::IDX_LOAD;
    end else if (state_q == ST_IDLE && !instrValid && idxReq) begin
      ixSel_q <= idxSel;
      ixOp_q  <= idxOp;
      link_q  <= (idxOp == front_end_pkg::IDX_LOAD) ? idxData
               : (idxSel == 3'h0) ? front_end_pkg::ADDR_RST : index_q[idxSel];
    end else if (state_q == ST_IXOP) begin
      if (ixOp_q == front_end_pkg::IDX_INC) begin
        link_q <= linkInc;
      end else if (ixOp_q == front_end_pkg::IDX_CPL) begin
        link_q <= ~link_q;
      end
    end else if (state_q == ST_MODIFY) begin
      link_q <= idxValue;
    end
  end

  // index 0 means no modification and is not stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 1; i <= 7; i++) begin
        index_q[i] <= front_end_pkg::ADDR_RST;
      end
    end else if (state_q == ST_IXWR && ixSel_q != 3'h0) begin
      index_q[ixSel_q] <= link_q;
    end
  end

  // storage access: address latch, read buffer, strobes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addrLatch_q <= front_end_pkg::ADDR_RST;
      readBuf_q   <= front_end_pkg::WORD_RST;
      memRead_q   <= 1'b0;
      memWrite_q  <= 1'b0;
    end else begin
      memRead_q  <= (state_q == ST_RDCLR);
      memWrite_q <= (state_q == ST_RDSAMP);
      if (state_q == ST_ADDR) begin
        addrLatch_q <= fLoc;
      end
      if (state_q == ST_RDCLR) begin
        readBuf_q <= front_end_pkg::WORD_RST;
      end else if (state_q == ST_RDSAMP) begin
        readBuf_q <= senseData;
      end else if (state_q == ST_SKIP) begin
        readBuf_q <= front_end_pkg::WORD_RST;
      end
    end
  end

  // operand register: the only path to and from the arithmetic side
  always_ff @(posedge core_clk) begin
    if (rst) begin
      operand_q <= front_end_pkg::WORD_RST;
    end else if (state_q == ST_XFER) begin
      operand_q <= shaped;
    end else if (state_q == ST_IDLE && arithLoad) begin
      operand_q <= arithData;
    end else if (state_q == ST_IDLE && operandCpl) begin
      operand_q <= ~operand_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ready_q   <= 1'b0;
      skip_q    <= 1'b0;
      repExit_q <= 1'b0;
      fault_q   <= 1'b0;
    end else begin
      ready_q   <= (state_q == ST_SKIP);
      repExit_q <= (state_q == ST_SKIP) && repeatActive && skipHit;
      if (state_q == ST_SKIP) begin
        skip_q <= skipHit;
      end
      if (state_q == ST_ADDIDX && isFault) begin
        fault_q <= 1'b1;
      end
    end
  end

  assign memAddr      = addrLatch_q;
  assign memRead      = memRead_q;
  assign memWrite     = memWrite_q;
  assign inhibitData  = readBuf_q;
  assign opCode       = fOpc;
  assign skipCond     = fSkip;
  assign operandMode  = fMode;
  assign indexSel     = fIdx;
  assign operandLoc   = fLoc;
  assign operandOut   = operand_q;
  assign operandReady = ready_q;
  assign skipNext     = skip_q;
  assign repeatExit   = repExit_q;
  assign busy         = (state_q != ST_IDLE);
  assign fault        = fault_q;
  assign idxLink      = link_q;
  assign shiftCount   = sc.count;
  assign shiftZero    = sc.zero;
endmodule : instruction_decode_front_end

// ---- dv/core_store_model.sv ----
/*
  Behavioural magnetic core storage seen through the front end's storage port.
  Assumes the front end's registered read and write strobes on core_clk.
*/
`timescale 1ns/1ps
module core_store_model (
  // clock
  input  wire logic        core_clk,
  // storage port
  input  wire logic [14:0] memAddr,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic [29:0] inhibitData,
  output wire logic [29:0] senseData
);
  logic [29:0] mem [0:31];
  logic [29:0] lastQ = 30'h00000000;

  // sense lines float outside the read half: show the inverse of the last word
  assign senseData = memRead ? mem[memAddr[4:0]] : ~lastQ;

  // read is destructive, so a missing restore leaves the word cleared
  always @(posedge core_clk) begin
    if (memRead) begin
      lastQ <= mem[memAddr[4:0]];
      mem[memAddr[4:0]] <= 30'h00000000;
    end
    if (memWrite) begin
      mem[memAddr[4:0]] <= inhibitData;
    end
  end
endmodule : core_store_model

// ---- dv/front_end_chk.sv ----
/*
  Concurrent checks on the front end's top-level ports.
  Assumes it is bound to the front end and that the arithmetic side holds
  sumReg, multReg and repeatActive steady while an instruction runs.
*/
`timescale 1ns/1ps
module front_end_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // stimulus side
  input wire logic        instrValid,
  input wire logic [29:0] instrWord,
  input wire logic        repeatActive,
  input wire logic [29:0] sumReg,
  input wire logic [29:0] multReg,
  input wire logic        arithLoad,
  input wire logic [29:0] arithData,
  input wire logic        operandCpl,
  input wire logic        mulDivStart,
  input wire logic        shiftLoad,
  input wire logic        shiftStep,
  input wire logic [29:0] senseData,
  // design outputs
  input wire logic [14:0] memAddr,
  input wire logic        memRead,
  input wire logic        memWrite,
  input wire logic [29:0] inhibitData,
  input wire logic [5:0]  opCode,
  input wire logic [2:0]  skipCond,
  input wire logic [2:0]  operandMode,
  input wire logic [2:0]  indexSel,
  input wire logic [29:0] operandOut,
  input wire logic        operandReady,
  input wire logic        skipNext,
  input wire logic        repeatExit,
  input wire logic        busy,
  input wire logic        fault,
  input wire logic [14:0] operandLoc,
  input wire logic [5:0]  shiftCount,
  input wire logic        shiftZero
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire take     = instrValid && !busy;
  wire badOpc   = instrWord[29:24] == 6'h00 || instrWord[29:24] == 6'h3f;
  wire readMode = instrWord[20:18] inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  wire skipTrue = skipCond == 3'h1 || (skipCond == 3'h2 && !multReg[29])
    || (skipCond == 3'h3 && multReg[29]) || (skipCond == 3'h4 && sumReg == 30'h0)
    || (skipCond == 3'h5 && sumReg != 30'h0) || (skipCond == 3'h6 && !sumReg[29])
    || (skipCond == 3'h7 && sumReg[29]);

  sequence take_read;
    take && !badOpc && readMode;
  endsequence
  sequence take_direct;
    take && !badOpc && !readMode;
  endsequence

  read_latency_a: assert property (take_read |=> !operandReady [*8] ##1 operandReady)
    else $error("read instruction finished at the wrong cycle");
  direct_latency_a: assert property (take_direct |=> !operandReady [*4] ##1 operandReady)
    else $error("direct operand instruction finished at the wrong cycle");
  field_split_a: assert property (take |=> opCode == $past(instrWord[29:24]) &&
    skipCond == $past(instrWord[23:21]) && operandMode == $past(instrWord[20:18]) &&
    indexSel == $past(instrWord[17:15])) else $error("instruction fields misplaced");
  fault_raise_a: assert property (take && badOpc |-> ##3 fault)
    else $error("fault not raised for an unused operation code");
  fault_halt_a: assert property (fault |=> fault && busy && !operandReady)
    else $error("computation went on after a fault");
  access_addr_a: assert property (memRead |-> memAddr == operandLoc)
    else $error("storage address differs from modified location");
  restore_word_a: assert property (memRead |=> memWrite && inhibitData == $past(senseData))
    else $error("write half does not restore the word read");
  full_word_a: assert property (memWrite && operandMode == 3'h3 |-> ##2
    operandOut == $past(inhibitData)) else $error("full word operand changed");
  skip_eval_a: assert property (operandReady |-> skipNext == skipTrue)
    else $error("skip decision wrong");
  repeat_exit_a: assert property (operandReady |-> repeatExit == (repeatActive && skipTrue))
    else $error("repeat exit wrong");
  muldiv_load_a: assert property (mulDivStart |=> shiftCount == 6'h1e && !shiftZero)
    else $error("shift counter not preset to thirty");
  shift_step_a: assert property (shiftStep && !shiftLoad && !mulDivStart && !shiftZero |=>
    shiftCount == $past(shiftCount) - 6'h01) else $error("shift counter step wrong");
  operand_load_a: assert property (arithLoad && !busy && !instrValid |=>
    operandOut == $past(arithData)) else $error("operand register load wrong");
  operand_cpl_a: assert property (operandCpl && !arithLoad && !busy && !instrValid |=>
    operandOut == ~$past(operandOut)) else $error("operand register not complemented");
endmodule : front_end_chk

// ---- dv/tb_instruction_decode_front_end.sv ----
/*
  Self-checking bench for the instruction decode front end with a core store model.
  Assumes the package, design files, store model and checker are compiled first.
*/
`timescale 1ns/1ps
module tb_instruction_decode_front_end;
  logic core_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, repeatActive = 1'b0;
  logic arithLoad = 1'b0, operandCpl = 1'b0, shiftLoad = 1'b0, mulDivStart = 1'b0;
  logic shiftStep = 1'b0, idxReq = 1'b0;
  logic [29:0] instrWord = 30'h0, sumReg = 30'h0, multReg = 30'h0, arithData = 30'h0;
  logic [5:0]  shiftLoadVal = 6'h00;
  front_end_pkg::index_op_t idxOp = front_end_pkg::IDX_LOAD;
  logic [2:0]  idxSel = 3'h0;
  logic [14:0] idxData = 15'h0000;
  logic [29:0] senseData, inhibitData, operandOut;
  logic [14:0] memAddr, operandLoc, idxLink;
  logic [5:0]  opCode, shiftCount;
  logic [2:0]  skipCond, operandMode, indexSel;
  logic memRead, memWrite, operandReady, skipNext, repeatExit, busy, fault, shiftZero;
  int bad_count = 0;
  int total_checks = 0;

  always #2.5 core_clk = ~core_clk;

  instruction_decode_front_end i_instruction_decode_front_end (.*);

  core_store_model i_core_store_model (.*);

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check(input string name, input logic [29:0] exp, input logic [29:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // bounded wait: for operandReady when sel is set, else for busy low
  task automatic wait_for(input bit sel);
    int n = 0;
    while ((sel ? operandReady : !busy) !== 1'b1) begin
      if (n == 20) begin
        check("handshake timeout", 30'h1, 30'h0);
        print_verdict();
      end
      n++;
      tick();
    end
  endtask : wait_for

  task automatic reset_dut;
    rst = 1'b1;
    repeat (5) tick();
    rst = 1'b0;
  endtask : reset_dut

  task automatic run_instr(input logic [29:0] word);
    instrWord = word;
    instrValid = 1'b1;
    tick();
    instrValid = 1'b0;
    wait_for(1'b1);
  endtask : run_instr

  task automatic idx_op(input front_end_pkg::index_op_t op, input logic [14:0] data);
    idxOp = op;
    idxSel = 3'h2;
    idxData = data;
    idxReq = 1'b1;
    tick();
    idxReq = 1'b0;
    wait_for(1'b0);
  endtask : idx_op

  function automatic logic [14:0] oc_add(input logic [14:0] a, input logic [14:0] b);
    logic [15:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[14:0] + {14'h0, s[15]};
  endfunction : oc_add

  function automatic logic [29:0] shape(input logic [2:0] m, input logic [29:0] z,
                                        input logic [14:0] loc);
    logic [14:0] h;
    h = (m == 3'h0 || m == 3'h4) ? loc : ((m == 3'h2 || m == 3'h6) ? z[29:15] : z[14:0]);
    if (m == 3'h3) return z;
    if (m == 3'h7) return sumReg;
    return {(m[2] && h[14]) ? 15'h7fff : 15'h0000, h};
  endfunction : shape

  task automatic t_index;
    idx_op(front_end_pkg::IDX_LOAD, 15'h7ffe);
    check("idxLink", 30'h7ffe, {15'h0, idxLink});
    run_instr({6'h11, 3'h0, 3'h0, 3'h2, 15'h0003});
    check("operandLoc carry", {15'h0, oc_add(15'h7ffe, 15'h0003)}, {15'h0, operandLoc});
    check("operandOut indexed", 30'h00000002, operandOut);
    idx_op(front_end_pkg::IDX_INC, 15'h0000);
    run_instr({6'h11, 3'h0, 3'h0, 3'h2, 15'h0003});
    check("operandLoc after step", {15'h0, oc_add(15'h7fff, 15'h0003)}, {15'h0, operandLoc});
    idx_op(front_end_pkg::IDX_CPL, 15'h0000);
    check("idxLink complemented", 30'h0, {15'h0, idxLink});
  endtask : t_index

  task automatic t_modes;
    i_core_store_model.mem[5] = 30'h2bcd4321;
    sumReg = 30'h1234abcd;
    for (int m = 0; m < 8; m++) begin
      run_instr({6'h11, 3'h0, m[2:0], 3'h0, 15'h4005});
      check("operandOut shaped", shape(m[2:0], 30'h2bcd4321, 15'h4005), operandOut);
    end
    check("restored word", 30'h2bcd4321, i_core_store_model.mem[5]);
  endtask : t_modes

  task automatic t_skip;
    logic [7:0] exp;
    for (int p = 0; p < 2; p++) begin
      tick();
      sumReg = p ? 30'h20000000 : 30'h00000000;
      multReg = p ? 30'h3ffffffe : 30'h00000001;
      repeatActive = p[0];
      for (int j = 0; j < 8; j++) begin
        run_instr({6'h20, j[2:0], 3'h0, 3'h0, 15'h0001});
        exp = (p ? 8'haa : 8'h56) >> j;
        check("skipNext", {29'h0, exp[0]}, {29'h0, skipNext});
        check("repeatExit", {29'h0, exp[0] && p[0]}, {29'h0, repeatExit});
      end
    end
    tick();
  endtask : t_skip

  task automatic t_arith_shift;
    arithData = 30'h15555555;
    arithLoad = 1'b1;
    tick();
    arithLoad = 1'b0;
    check("operandOut loaded", 30'h15555555, operandOut);
    operandCpl = 1'b1;
    tick();
    operandCpl = 1'b0;
    check("operandOut complemented", 30'h2aaaaaaa, operandOut);
    mulDivStart = 1'b1;
    tick();
    mulDivStart = 1'b0;
    check("shiftCount preset", 30'h1e, {24'h0, shiftCount});
    shiftStep = 1'b1;
    repeat (2) tick();
    shiftStep = 1'b0;
    check("shiftCount stepped", 30'h1c, {24'h0, shiftCount});
    shiftLoadVal = 6'h3f;
    shiftLoad = 1'b1;
    tick();
    shiftLoad = 1'b0;
    check("shiftCount max", 30'h3f, {24'h0, shiftCount});
  endtask : t_arith_shift

  task automatic t_fault;
    for (int c = 0; c < 2; c++) begin
      reset_dut();
      instrWord = {c ? 6'h3f : 6'h00, 3'h1, 3'h3, 3'h0, 15'h0005};
      instrValid = 1'b1;
      tick();
      instrValid = 1'b0;
      repeat (12) tick();
      check("fault", 30'h1, {29'h0, fault});
      check("busy held", 30'h1, {29'h0, busy});
    end
    reset_dut();
  endtask : t_fault

  initial begin
    reset_dut();
    t_index();
    t_modes();
    t_skip();
    t_arith_shift();
    t_fault();
    print_verdict();
  end
endmodule : tb_instruction_decode_front_end

bind instruction_decode_front_end front_end_chk i_front_end_chk (.*);
